//--- logic/opaa_phase_adjust.v
// What this block does
// - Adjust an output only when enabled, in adjust or alignment mode; only adjust mode needs a nonzero amount written.
// - Arm source picks soft arm bit rise, APLL lock, DPLL lock or GPIO.
// - Trigger source picks soft trigger bit, APLL, DPLL lock, input clock or GPIO.
// - Trigger invert flips the selected trigger level.
// - A trigger counts only after arming; unarmed triggers do nothing.
// - One trigger adjusts all enabled outputs, each by its own amount.
// - No adjustment on an output whose medium divider setting is zero.
// - Adjustment changes one divider period; positive lengthens, negative shortens high.
// - State machine reset cancels an armed adjustment and returns to idle.
// - Status shows armed, busy, and a latched adjustment-done bit.
// - Amount is signed, counted in half high-speed divider periods.
// - Trigger bit does not self-clear when output period beats master clock.
// - Alignment mode resets medium and low dividers before applying adjustments.
// - Format inversion and polarity bit set phase versus CML outputs.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "opaa_regs.vh"

module opaa_phase_adjust #(
  parameter N_OUT  = 3,
  parameter N_GPIO = 4
) (
  input  wire              i_sys_clk,
  input  wire              i_rst,
  input  wire [7:0]        i_addr,
  input  wire [7:0]        i_wr_data,
  input  wire              i_wr,
  input  wire              i_rd,
  output reg  [7:0]        o_rd_data,
  input  wire              i_apll_lock,
  input  wire              i_dpll_lock,
  input  wire              i_dpll_in_clk,
  input  wire [N_GPIO-1:0] i_gpio,
  output reg  [N_OUT-1:0]  o_out_clk,
  output reg               o_armed,
  output reg               o_busy
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_ARMED = 2'd1;
  localparam ST_BUSY  = 2'd2;

  reg  [7:0]        ctrl_reg;
  reg  [7:0]        src_reg;
  reg               done_reg;
  reg  [1:0]        state_reg;
  reg  [1:0]        state_next;
  reg  [7:0]        ctrl_one_reg [0:N_OUT-1];
  reg  [7:0]        amount_reg   [0:N_OUT-1];
  reg  [7:0]        ctrl_two_reg [0:N_OUT-1];
  reg  [7:0]        low_div_reg  [0:N_OUT-1];
  reg  [N_GPIO+2:0] sync1_reg;
  reg  [N_GPIO+2:0] sync2_reg;
  reg               arm_prev_reg;
  reg               trg_prev_reg;
  reg               arm_lvl;
  reg               trg_lvl;
  reg               hit;
  reg  [7:0]        rd_next;
  reg  [1:0]        sel;
  integer           k;
  wire [N_OUT-1:0]  pend;
  wire              arm_ev;
  wire              trg_ev;
  wire              sm_rst;
  wire              apply;
  wire              finish;
  wire              wr_ctrl;
  wire              out_hit;
  wire [1:0]        out_fld;
  wire [7:0]        out_rel;

  // Software writes a one to the reset bit; it acts as a pulse and is not stored.
  assign wr_ctrl = i_wr && (i_addr == `OPAA_ADJ_CTRL_ONE);
  assign sm_rst  = wr_ctrl && i_wr_data[`OPAA_RST_BIT];
  assign out_rel = i_addr - `OPAA_OUT_BASE;
  assign out_fld = out_rel[1:0];
  assign out_hit = (i_addr >= `OPAA_OUT_BASE) && (out_rel[7:2] < N_OUT);

  // Lock, input clock and GPIO levels come from other domains.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_reg <= {(N_GPIO+3){1'b0}};
      sync2_reg <= {(N_GPIO+3){1'b0}};
    end else begin
      sync1_reg <= {i_gpio, i_dpll_in_clk, i_dpll_lock, i_apll_lock};
      sync2_reg <= sync1_reg;
    end
  end

  // Source selection works on levels; events are rising edges of the chosen level.
  always @* begin
    sel = src_reg[1:0];
    case (src_reg[3:0])
      `OPAA_ARM_SOFT: arm_lvl = ctrl_reg[`OPAA_ARM_BIT];
      `OPAA_ARM_APLL: arm_lvl = sync2_reg[0];
      `OPAA_ARM_DPLL: arm_lvl = sync2_reg[1];
      default: begin
        if (src_reg[3:2] == `OPAA_SRC_GPIO_HI)
          arm_lvl = sync2_reg[3 + sel];
        else
          arm_lvl = 1'b0;
      end
    endcase
    case (src_reg[7:4])
      `OPAA_TRG_SOFT:  trg_lvl = ctrl_reg[`OPAA_SOFT_TRIGGER_BIT_BIT];
      `OPAA_TRG_APLL:  trg_lvl = sync2_reg[0];
      `OPAA_TRG_DPLL:  trg_lvl = sync2_reg[1];
      `OPAA_TRG_INCLK: trg_lvl = sync2_reg[2];
      default: begin
        if (src_reg[7:6] == `OPAA_SRC_GPIO_HI)
          trg_lvl = sync2_reg[3 + src_reg[5:4]];
        else
          trg_lvl = 1'b0;
      end
    endcase
    trg_lvl = trg_lvl ^ ctrl_reg[`OPAA_TRIGGER_INVERT_BIT];
  end

  // The previous levels follow the chosen levels every cycle and clear only on i_rst,
  // so a source change to a high level raises an edge.
  assign arm_ev = arm_lvl && !arm_prev_reg;
  assign trg_ev = trg_lvl && !trg_prev_reg;
  assign apply  = (state_reg == ST_ARMED) && trg_ev && !sm_rst;
  assign finish = (state_reg == ST_BUSY) && !(|pend) && !sm_rst;

  always @* begin
    case (state_reg)
      ST_IDLE:  state_next = arm_ev ? ST_ARMED : ST_IDLE;
      ST_ARMED: state_next = trg_ev ? ST_BUSY : ST_ARMED;
      ST_BUSY:  state_next = (|pend) ? ST_BUSY : ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
    if (sm_rst)
      state_next = ST_IDLE;
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg    <= ST_IDLE;
      arm_prev_reg <= 1'b0;
      trg_prev_reg <= 1'b0;
      o_armed      <= 1'b0;
      o_busy       <= 1'b0;
    end else begin
      state_reg    <= state_next;
      arm_prev_reg <= arm_lvl;
      trg_prev_reg <= trg_lvl;
      o_armed      <= (state_next == ST_ARMED);
      o_busy       <= (state_next == ST_BUSY);
    end
  end

  // Register writes; the arm clear comes before software, the done set and trigger clear after it.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= `OPAA_CTRL_RESET;
      src_reg  <= `OPAA_SRC_RESET;
      done_reg <= 1'b0;
      for (k = 0; k < N_OUT; k = k + 1) begin
        ctrl_one_reg[k] <= 8'h00;
        amount_reg[k]   <= 8'h00;
        ctrl_two_reg[k] <= 8'h00;
        low_div_reg[k]  <= 8'h00;
      end
    end else begin
      // The arm bit acts once; it drops back so the next write of one is a new rise.
      ctrl_reg[`OPAA_ARM_BIT] <= 1'b0;
      if (wr_ctrl)
        ctrl_reg <= {2'b00, i_wr_data[5], 1'b0, i_wr_data[3:0]};
      if (i_wr && i_addr == `OPAA_ADJ_SOURCE_SELECT)
        src_reg <= i_wr_data;
      if (i_wr && i_addr == `OPAA_ADJ_STATUS_REG && i_wr_data[`OPAA_DONE_BIT])
        done_reg <= 1'b0;
      if (i_wr && out_hit) begin
        for (k = 0; k < N_OUT; k = k + 1) begin
          if (out_rel[7:2] == k) begin
            case (out_fld)
              `OPAA_OUT_CTRL_ONE:     ctrl_one_reg[k] <= i_wr_data;
              `OPAA_OUT_PHASE_AMOUNT: amount_reg[k]   <= i_wr_data;
              `OPAA_OUT_CTRL_TWO:     ctrl_two_reg[k] <= i_wr_data;
              default:                low_div_reg[k]  <= i_wr_data;
            endcase
          end
        end
      end
      if (finish) begin
        done_reg <= 1'b1;
        // A fast output period would re-trigger on a held bit, so software clears it.
        if (!ctrl_reg[`OPAA_FAST_BIT] && !(wr_ctrl && i_wr_data[`OPAA_SOFT_TRIGGER_BIT_BIT]))
          ctrl_reg[`OPAA_SOFT_TRIGGER_BIT_BIT] <= 1'b0;
      end
    end
  end

  // Read data stand in the cycle after the strobe; unmapped addresses read zero.
  always @* begin
    rd_next = 8'h00;
    hit     = 1'b0;
    if (i_addr == `OPAA_ADJ_CTRL_ONE)
      rd_next = ctrl_reg;
    else if (i_addr == `OPAA_ADJ_SOURCE_SELECT)
      rd_next = src_reg;
    else if (i_addr == `OPAA_ADJ_STATUS_REG)
      rd_next = {5'b00000, done_reg, o_busy, o_armed};
    else if (out_hit) begin
      for (k = 0; k < N_OUT; k = k + 1) begin
        if (out_rel[7:2] == k && !hit) begin
          hit = 1'b1;
          case (out_fld)
            `OPAA_OUT_CTRL_ONE:     rd_next = ctrl_one_reg[k];
            `OPAA_OUT_PHASE_AMOUNT: rd_next = amount_reg[k];
            `OPAA_OUT_CTRL_TWO:     rd_next = ctrl_two_reg[k];
            default:                rd_next = low_div_reg[k];
          endcase
        end
      end
    end
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst)
      o_rd_data <= 8'h00;
    else
      o_rd_data <= i_rd ? rd_next : 8'h00;
  end

  // One system clock stands for half a high-speed divider period here.
  genvar g;
  generate
    for (g = 0; g < N_OUT; g = g + 1) begin : g_out
      reg  [9:0] cnt_reg;
      reg        high_reg;
      reg        pend_reg;
      reg  [7:0] ls_cnt_reg;
      reg        ls_out_reg;
      wire [6:0] div_val;
      wire       used;
      wire       qual;
      wire       align;
      wire [9:0] base_len;
      wire [9:0] adj_len;
      wire [9:0] high_len;
      wire       wrap;
      wire       ms_rise;
      wire       ms_val;

      assign div_val  = ctrl_one_reg[g][6:0];
      assign used     = (div_val != 7'h00);
      assign align    = !ctrl_reg[`OPAA_MODE_BIT];
      // Adjust mode needs a nonzero amount; alignment resets every enabled output with a nonzero divider.
      assign qual     = ctrl_one_reg[g][`OPAA_ENABLE_BIT] && used &&
                        (align || amount_reg[g] != 8'h00);
      assign base_len = {3'b000, div_val} + 10'd1;
      assign adj_len  = base_len + {{2{amount_reg[g][7]}}, amount_reg[g]};
      // A too large negative amount is clamped so the high time never vanishes.
      assign high_len = (adj_len[9] || adj_len == 10'd0) ? 10'd1 : adj_len;
      assign wrap     = (cnt_reg <= 10'd1);
      assign ms_rise  = wrap && !high_reg;
      assign ms_val   = (low_div_reg[g] != 8'h00) ? ls_out_reg : high_reg;
      assign pend[g]  = pend_reg;

      always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          cnt_reg    <= 10'd1;
          high_reg   <= 1'b0;
          pend_reg   <= 1'b0;
          ls_cnt_reg <= 8'h00;
          ls_out_reg <= 1'b0;
          o_out_clk[g] <= 1'b0;
        end else begin
          if (apply && qual && align) begin
            high_reg   <= 1'b1;
            cnt_reg    <= high_len;
            ls_cnt_reg <= 8'h00;
            ls_out_reg <= 1'b1;
          end else if (wrap) begin
            high_reg <= !high_reg;
            if (!high_reg && pend_reg && used) begin
              cnt_reg  <= high_len;
              pend_reg <= 1'b0;
            end else
              cnt_reg <= base_len;
            if (ms_rise) begin
              if (ls_cnt_reg >= low_div_reg[g]) begin
                ls_cnt_reg <= 8'h00;
                ls_out_reg <= !ls_out_reg;
              end else
                ls_cnt_reg <= ls_cnt_reg + 8'h01;
            end
          end else
            cnt_reg <= cnt_reg - 10'd1;
          if (apply && qual && !align)
            pend_reg <= 1'b1;
          else if (sm_rst)
            pend_reg <= 1'b0;
          o_out_clk[g] <= ms_val ^ ctrl_two_reg[g][`OPAA_POL_BIT] ^
                          ctrl_two_reg[g][`OPAA_FMTINV_BIT];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

//--- pkg/opaa_regs.vh
`ifndef OPAA_REGS_VH
`define OPAA_REGS_VH

// Register offsets, byte addressed, 8-bit data.
`define OPAA_ADJ_CTRL_ONE      8'h00
`define OPAA_ADJ_SOURCE_SELECT 8'h01
`define OPAA_ADJ_STATUS_REG    8'h02
`define OPAA_OUT_BASE          8'h04
`define OPAA_OUT_STRIDE        8'h04
`define OPAA_OUT_CTRL_ONE      2'h0
`define OPAA_OUT_PHASE_AMOUNT  2'h1
`define OPAA_OUT_CTRL_TWO      2'h2
`define OPAA_OUT_LOW_DIVIDER   2'h3

// adj_ctrl_one fields.
`define OPAA_MODE_BIT     0
`define OPAA_ARM_BIT      1
`define OPAA_SOFT_TRIGGER_BIT_BIT     2
`define OPAA_TRIGGER_INVERT_BIT     3
`define OPAA_RST_BIT      4
`define OPAA_FAST_BIT     5

// adj_status_reg fields.
`define OPAA_ARMED_BIT    0
`define OPAA_BUSY_BIT     1
`define OPAA_DONE_BIT     2

// out_ctrl_one fields.
`define OPAA_ENABLE_BIT   7
// out_ctrl_two fields.
`define OPAA_POL_BIT      0
`define OPAA_FMTINV_BIT   1

// Arm source codes.
`define OPAA_ARM_SOFT     4'h1
`define OPAA_ARM_APLL     4'h2
`define OPAA_ARM_DPLL     4'h3
// Trigger source codes.
`define OPAA_TRG_SOFT     4'h0
`define OPAA_TRG_APLL     4'h1
`define OPAA_TRG_DPLL     4'h2
`define OPAA_TRG_INCLK    4'h3
// Codes 4 to 7 pick GPIO 0 to 3 for either source.
`define OPAA_SRC_GPIO_HI  2'h1

// Reset values.
`define OPAA_CTRL_RESET   8'h00
`define OPAA_SRC_RESET    8'h01

`endif

//--- verification/opaa_phase_adjust_properties.sv
`timescale 1ns/1ps
`default_nettype none
module opaa_phase_adjust_properties #(
  parameter N_OUT  = 3,
  parameter N_GPIO = 4
) (
  input wire logic              i_sys_clk,
  input wire logic              i_rst,
  input wire logic [7:0]        i_addr,
  input wire logic [7:0]        i_wr_data,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [7:0]        o_rd_data,
  input wire logic              i_apll_lock,
  input wire logic              i_dpll_lock,
  input wire logic              i_dpll_in_clk,
  input wire logic [N_GPIO-1:0] i_gpio,
  input wire logic [N_OUT-1:0]  o_out_clk,
  input wire logic              o_armed,
  input wire logic              o_busy
);
  // Shadow of the written selection and trigger bits; the trigger check only fires when a rise is certain.
  logic [7:0] src_q;
  logic [1:0] trg_q;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      src_q <= 8'h01;
      trg_q <= 2'h0;
    end else if (i_wr && i_addr == 8'h01) begin
      src_q <= i_wr_data;
    end else if (i_wr && i_addr == 8'h00) begin
      trg_q <= i_wr_data[3:2];
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_ctrl(b);
    i_wr && i_addr == 8'h00 && i_wr_data[b] && !i_wr_data[4];
  endsequence
  a_rd_idle: assert property (!$past(i_rd) |-> o_rd_data == 8'h00)
    else $error("read data not zero outside a read");
  a_status_read: assert property ($past(i_rd && i_addr == 8'h02) |->
    o_rd_data[1:0] == $past({o_busy, o_armed}) && o_rd_data[7:3] == 5'h00)
    else $error("status read wrong");
  a_one_state: assert property (!(o_armed && o_busy))
    else $error("armed and busy together");
  a_busy_armed: assert property ($rose(o_busy) |-> $past(o_armed))
    else $error("busy without arming");
  a_rst_cancel: assert property (i_wr && i_addr == 8'h00 && i_wr_data[4] |=> !o_armed && !o_busy)
    else $error("machine reset did not idle");
  a_busy_ends: assert property ($rose(o_busy) |-> ##[1:600] !o_busy)
    else $error("busy never ended");
  a_soft_arm: assert property (!o_armed && !o_busy && src_q[3:0] == 4'h1 ##0 s_ctrl(1) |=> ##1 o_armed)
    else $error("soft arm missed");
  a_soft_soft_trigger_bit: assert property (o_armed && src_q[7:4] == 4'h0 && trg_q == 2'h0 ##0 s_ctrl(2) ##0
    !i_wr_data[3] |=> ##1 o_busy)
    else $error("soft trigger missed");
endmodule
bind opaa_phase_adjust opaa_phase_adjust_properties #(.N_OUT(N_OUT), .N_GPIO(N_GPIO)) u_props (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
  .i_rd(i_rd), .o_rd_data(o_rd_data), .i_apll_lock(i_apll_lock), .i_dpll_lock(i_dpll_lock),
  .i_dpll_in_clk(i_dpll_in_clk), .i_gpio(i_gpio), .o_out_clk(o_out_clk), .o_armed(o_armed),
  .o_busy(o_busy));
`default_nettype wire

//--- verification/test_output_phase_adjust_align.sv
`timescale 1ns/1ps
`default_nettype none
module test_output_phase_adjust_align;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdat;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [6:0] ext = 7'h00;
  logic [2:0] oc;
  logic       armed;
  logic       busy;
  int         n_mismatch = 0;
  int         comparisons = 0;
  int         hi [3];
  int         odd [3];
  int         odd_len [3];
  int         nom [3] = '{4, 1, 4};
  opaa_phase_adjust opaa_phase_adjust_i (.i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wd),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rdat), .i_apll_lock(ext[0]), .i_dpll_lock(ext[1]),
    .i_dpll_in_clk(ext[2]), .i_gpio(ext[6:3]), .o_out_clk(oc), .o_armed(armed), .o_busy(busy));
  initial begin
    forever #10 clk = ~clk;
  end
  // High runs are timed at the falling edge, clear of the edge that moves the outputs.
  always @(negedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (oc[i]) begin
        hi[i]++;
      end else begin
        if (hi[i] != 0 && hi[i] != nom[i]) begin
          odd[i]++;
          odd_len[i] = hi[i];
        end
        hi[i] = 0;
      end
    end
  end
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, e);
    comparisons++;
    if (got !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic wrr(input logic [7:0] a, d);
    addr <= a;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(rdat, e);
    @(posedge clk);
  endtask
  task automatic wt(input bit sel, input logic v);
    int k;
    comparisons++;
    for (k = 0; k < 700 && (sel ? busy : armed) !== v; k++) @(negedge clk);
    if (k == 700) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      conclude();
    end
    @(posedge clk);
  endtask
  task automatic t_adj(input logic [7:0] amt, input int len);
    wrr(8'h05, amt);
    wrr(8'h01, 8'h01);
    wrr(8'h00, 8'h11);
    wrr(8'h00, 8'h05);
    rdc(8'h02, 8'h00);
    wrr(8'h00, 8'h01);
    wrr(8'h00, 8'h03);
    rdc(8'h02, 8'h01);
    odd = '{0, 0, 0};
    wrr(8'h00, 8'h05);
    wt(1, 1);
    wt(1, 0);
    repeat (30) @(posedge clk);
    rdc(8'h02, 8'h04);
    rdc(8'h00, 8'h01);
    wrr(8'h02, 8'h04);
    cmp(odd[0], 1);
    cmp(odd_len[0], len);
    cmp(odd[1], 0);
    cmp(odd[2], 0);
    $display("adjust %h done", amt);
  endtask
  task automatic t_cancel;
    wrr(8'h00, 8'h03);
    wrr(8'h00, 8'h11);
    wrr(8'h00, 8'h05);
    rdc(8'h02, 8'h00);
    wrr(8'h00, 8'h01);
    $display("cancel done");
  endtask
  task automatic t_fast;
    wrr(8'h00, 8'h23);
    wrr(8'h00, 8'h27);
    wt(1, 1);
    wt(1, 0);
    rdc(8'h00, 8'h25);
    wrr(8'h00, 8'h23);
    wrr(8'h00, 8'h27);
    wt(1, 1);
    wt(1, 0);
    wrr(8'h00, 8'h01);
    wrr(8'h02, 8'h04);
    $display("fast trigger done");
  endtask
  task automatic t_ext(input logic [3:0] a, t, input logic inv);
    wrr(8'h01, {t, a});
    wrr(8'h00, {4'h1, inv, 3'h1});
    ext[a - (a < 4 ? 2 : 1)] <= 1'b1;
    wt(0, 1);
    rdc(8'h02, 8'h01);
    ext[t - 1] <= !inv;
    wt(1, 1);
    wt(1, 0);
    ext <= 7'h00;
    repeat (4) @(posedge clk);
    rdc(8'h02, 8'h04);
    wrr(8'h02, 8'h04);
    $display("sources %h %h done", a, t);
  endtask
  task automatic t_align;
    wrr(8'h05, 8'h00);
    wrr(8'h0d, 8'h00);
    wrr(8'h0c, 8'h83);
    wrr(8'h0e, 8'h01);
    wrr(8'h01, 8'h01);
    wrr(8'h00, 8'h10);
    wrr(8'h00, 8'h02);
    wrr(8'h00, 8'h04);
    wt(1, 1);
    wt(1, 0);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      cmp(oc[2] ^ oc[0], 1);
    end
    $display("align done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(8'h00, 8'h00);
    rdc(8'h01, 8'h01);
    rdc(8'h02, 8'h00);
    rdc(8'hf0, 8'h00);
    wrr(8'h04, 8'h83);
    wrr(8'h08, 8'h80);
    wrr(8'h09, 8'h02);
    wrr(8'h0c, 8'h03);
    wrr(8'h0d, 8'h02);
    t_adj(8'h02, 6);
    t_adj(8'h07, 11);
    t_adj(8'hfe, 2);
    t_cancel;
    t_fast;
    t_ext(4'h2, 4'h2, 1'b0);
    t_ext(4'h3, 4'h1, 1'b0);
    t_ext(4'h4, 4'h3, 1'b0);
    t_ext(4'h5, 4'h5, 1'b1);
    t_ext(4'h7, 4'h6, 1'b0);
    t_align;
    conclude();
  end
endmodule
`default_nettype wire
